// File: hw/input_sync.v
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes inputs may be asynchronous to clock; first stage is read only by the second.
*/
module input_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input  wire             clock,
  input  wire             rstn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg stable_reg;
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta_reg   <= RESET_VALUE[i];
          stable_reg <= RESET_VALUE[i];
        end else begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule // input_sync

// File: hw/supervisor_defs.vh
/*
  Timing constants for the window watchdog supervisor core.
  Assumes a 40 MHz core clock; times are kept in their own unit and converted to cycles.
*/
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH

`define CLK_MHZ              40
`define CLK_KHZ              40000
// Overvoltage flag delay and clear pulse width, in microseconds
`define OV_DELAY_US          5
`define OV_DELAY_CYC         (`OV_DELAY_US * `CLK_MHZ)
`define CLEAR_WIDTH_US       5
`define CLEAR_WIDTH_CYC      (`CLEAR_WIDTH_US * `CLK_MHZ)
// Watchdog fault pulse lengths, in milliseconds
`define FAST_PULSE_MS        50
`define FAST_PULSE_CYC       (`FAST_PULSE_MS * `CLK_KHZ)
`define SLOW_PULSE_MS        100
`define SLOW_PULSE_CYC       (`SLOW_PULSE_MS * `CLK_KHZ)
// Default fast window limit and reset timeout, in milliseconds
`define FAST_LIMIT_MS        8
`define SLOW_LIMIT_FACTOR    10
`define RESET_TIMEOUT_MS     10
`define SYNC_STAGES          2

`endif

// File: hw/window_watchdog_supervisor.v
/*
  Digital core of a supply supervisor: window watchdog, latched overvoltage flag,
  supply-fault reset with timeout stretch.
  Assumes window and overvoltage comparator levels arrive from analog logic, one clock.
*/
`include "supervisor_defs.vh"

module window_watchdog_supervisor #(
  parameter FAST_LIMIT_MS   = `FAST_LIMIT_MS,
  parameter RESET_TIMEOUT_MS = `RESET_TIMEOUT_MS,
  parameter FAST_LIMIT_CYC  = FAST_LIMIT_MS * `CLK_KHZ,
  parameter SLOW_LIMIT_CYC  = FAST_LIMIT_MS * `SLOW_LIMIT_FACTOR * `CLK_KHZ,
  parameter RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * `CLK_KHZ,
  parameter FAST_PULSE_CYC  = `FAST_PULSE_CYC,
  parameter SLOW_PULSE_CYC  = `SLOW_PULSE_CYC
) (
  input  wire clock,
  input  wire rstn,
  input  wire in_window,
  input  wire over_voltage,
  input  wire fault_clear_n,
  input  wire watchdog_strobe,
  output wire supply_reset_n,
  output wire overvoltage_flag_n,
  output wire watchdog_fault_n
);

  localparam CW = 32;
  localparam [CW-1:0] FAST_LIM  = FAST_LIMIT_CYC;
  localparam [CW-1:0] SLOW_LIM  = SLOW_LIMIT_CYC;
  localparam [CW-1:0] RST_TO    = RESET_TIMEOUT_CYC;
  localparam [CW-1:0] FAST_PUL  = FAST_PULSE_CYC;
  localparam [CW-1:0] SLOW_PUL  = SLOW_PULSE_CYC;
  localparam [CW-1:0] OV_DLY    = `OV_DELAY_CYC;
  localparam [CW-1:0] CLR_WID   = `CLEAR_WIDTH_CYC;

  localparam [2:0] WD_IDLE  = 3'h1;
  localparam [2:0] WD_TIME  = 3'h2;
  localparam [2:0] WD_PULSE = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  wire [3:0] synced;
  input_sync #(
    .WIDTH       (4),
    .RESET_VALUE (4'hD)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({watchdog_strobe, fault_clear_n, over_voltage, in_window}),
    .sync_out (synced)
  );

  wire strobe_s = synced[3];
  wire clear_s  = synced[2];
  wire ov_s     = synced[1];
  wire win_s    = synced[0];

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection

  reg strobe_d_reg;
  reg reset_d_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strobe_d_reg <= 1'b1;
      reset_d_reg  <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_s;
      reset_d_reg  <= supply_reset_n;
    end
  end
  wire strobe_fall = strobe_d_reg & ~strobe_s;
  wire reset_rise  = supply_reset_n & ~reset_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Overvoltage flag and clear input

  reg [CW-1:0] ov_cnt_reg;
  reg [CW-1:0] clr_cnt_reg;
  reg          ov_flag_reg;
  reg          long_clear_reg;
  // Clear activity counts only once the overvoltage condition has ended
  wire         clear_armed = !clear_s && !ov_s;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ov_cnt_reg     <= 32'h0;
      clr_cnt_reg    <= 32'h0;
      ov_flag_reg    <= 1'b0;
      long_clear_reg <= 1'b0;
    end else begin
      if (!ov_s)
        ov_cnt_reg <= 32'h0;
      else if (ov_cnt_reg < OV_DLY)
        ov_cnt_reg <= ov_cnt_reg + 32'h1;
      if (!clear_armed)
        clr_cnt_reg <= 32'h0;
      else if (clr_cnt_reg <= CLR_WID)
        clr_cnt_reg <= clr_cnt_reg + 32'h1;
      if (ov_s && ov_cnt_reg + 32'h1 >= OV_DLY)
        ov_flag_reg <= 1'b1;
      else if (clear_armed && clr_cnt_reg + 32'h1 >= CLR_WID)
        ov_flag_reg <= 1'b0;
      long_clear_reg <= clear_armed && clr_cnt_reg >= CLR_WID;
    end
  end
  assign overvoltage_flag_n = ~ov_flag_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Supply-fault reset with timeout stretch

  reg [CW-1:0] rst_cnt_reg;
  reg          rst_out_reg;
  wire         rst_cause = !win_s || long_clear_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_reg <= 32'h0;
      rst_out_reg <= 1'b0;
    end else if (rst_cause) begin
      rst_cnt_reg <= 32'h0;
      rst_out_reg <= 1'b0;
    end else if (!rst_out_reg) begin
      if (rst_cnt_reg + 32'h1 >= RST_TO)
        rst_out_reg <= 1'b1;
      else
        rst_cnt_reg <= rst_cnt_reg + 32'h1;
    end
  end
  assign supply_reset_n = rst_out_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Window watchdog

  reg [2:0]    wd_state_reg;
  reg [2:0]    wd_state_next;
  reg [CW-1:0] wd_cnt_reg;
  reg [CW-1:0] wd_cnt_next;
  reg [CW-1:0] pulse_cnt_reg;
  reg [CW-1:0] pulse_cnt_next;

  always @* begin
    wd_state_next  = wd_state_reg;
    wd_cnt_next    = wd_cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    case (wd_state_reg)
      WD_IDLE: begin
        wd_cnt_next = 32'h0;
        if (strobe_fall)
          wd_state_next = WD_TIME;
      end
      WD_TIME: begin
        if (wd_cnt_reg >= SLOW_LIM) begin
          wd_cnt_next    = 32'h0;
          wd_state_next  = WD_PULSE;
          pulse_cnt_next = SLOW_PUL;
        end else if (reset_rise) begin
          wd_cnt_next = 32'h0;
        end else if (strobe_fall) begin
          wd_cnt_next = 32'h0;
          if (wd_cnt_reg < FAST_LIM) begin
            wd_state_next  = WD_PULSE;
            pulse_cnt_next = FAST_PUL;
          end
        end else begin
          wd_cnt_next = wd_cnt_reg + 32'h1;
        end
      end
      WD_PULSE: begin
        wd_cnt_next    = 32'h0;
        pulse_cnt_next = pulse_cnt_reg - 32'h1;
        if (pulse_cnt_reg == 32'h1)
          wd_state_next = WD_TIME;
      end
      default: begin
        wd_state_next  = WD_IDLE;
        wd_cnt_next    = 32'h0;
        pulse_cnt_next = 32'h0;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wd_state_reg  <= WD_IDLE;
      wd_cnt_reg    <= 32'h0;
      pulse_cnt_reg <= 32'h0;
    end else begin
      wd_state_reg  <= wd_state_next;
      wd_cnt_reg    <= wd_cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog fault output

  reg wd_fault_reg;
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      wd_fault_reg <= 1'b1;
    else
      wd_fault_reg <= ~(wd_state_next == WD_PULSE);
  end
  assign watchdog_fault_n = wd_fault_reg;

endmodule // window_watchdog_supervisor

// File: sim/mcu_model.sv
/* Processor that strobes the watchdog.
   Assumes period counts cycles between falls; zero leaves the strobe high. */
module mcu_model (
  input  wire        clock,
  input  wire [15:0] period,
  output logic       watchdog_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] n_reg = '0;
  initial watchdog_strobe = 1'b1;
  always @(posedge clock) begin
    n_reg <= (period == 0 || n_reg >= period - 1) ? '0 : n_reg + 1;
    watchdog_strobe <= !(period != 0 && n_reg < 2);
  end
endmodule // mcu_model

// File: sim/supervisor_monitor.sv
/* Checker for the supervisor core, bound to its ports.
   Assumes the core's small timing parameters are handed on by the bind. */
`include "supervisor_defs.vh"
module supervisor_monitor #(
  parameter FAST_LIMIT_CYC    = 20,
  parameter SLOW_LIMIT_CYC    = 200,
  parameter RESET_TIMEOUT_CYC = 50,
  parameter FAST_PULSE_CYC    = 30,
  parameter SLOW_PULSE_CYC    = 60
) (
  input wire clock,
  input wire rstn,
  input wire in_window,
  input wire over_voltage,
  input wire fault_clear_n,
  input wire watchdog_strobe,
  input wire supply_reset_n,
  input wire overvoltage_flag_n,
  input wire watchdog_fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] win_reg, clr_reg, low_reg, gap_reg;
  logic        seen_reg;
  // Run lengths of the inputs and of the fault pulse
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {win_reg, clr_reg, low_reg, gap_reg, seen_reg} <= '0;
    end else begin
      win_reg  <= (in_window && fault_clear_n) ? win_reg + 1 : '0;
      clr_reg  <= (!fault_clear_n && !over_voltage) ? clr_reg + 1 : '0;
      low_reg  <= watchdog_fault_n ? '0 : low_reg + 1;
      gap_reg  <= ($fell(watchdog_strobe) || $rose(watchdog_fault_n)
                   || $rose(supply_reset_n)) ? '0 : gap_reg + 1;
      seen_reg <= seen_reg || $fell(watchdog_strobe);
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_rst_low; !in_window [*5] |-> !supply_reset_n; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset not low");
  property p_rst_early; $rose(supply_reset_n) |-> win_reg >= RESET_TIMEOUT_CYC; endproperty
  a_rst_early: assert property (p_rst_early) else $error("reset early");
  property p_ov_clr; $rose(overvoltage_flag_n) |-> clr_reg >= `CLEAR_WIDTH_CYC; endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("flag freed early");
  property p_clr_rst; clr_reg == `CLEAR_WIDTH_CYC + 6 |-> !supply_reset_n; endproperty
  a_clr_rst: assert property (p_clr_rst) else $error("no clear reset");
  property p_wd_len;
    $rose(watchdog_fault_n) |-> low_reg == FAST_PULSE_CYC || low_reg == SLOW_PULSE_CYC;
  endproperty
  a_wd_len: assert property (p_wd_len) else $error("pulse length");
  property p_wd_fast;
    $fell(watchdog_strobe) && seen_reg && watchdog_fault_n && gap_reg < FAST_LIMIT_CYC - 4
      |-> ##[1:8] !watchdog_fault_n;
  endproperty
  a_wd_fast: assert property (p_wd_fast) else $error("no fast pulse");
  property p_wd_slow; seen_reg && gap_reg == SLOW_LIMIT_CYC + 6 |-> !watchdog_fault_n; endproperty
  a_wd_slow: assert property (p_wd_slow) else $error("no slow pulse");
  property p_wd_ok;
    $fell(watchdog_strobe) && seen_reg && watchdog_fault_n && gap_reg > FAST_LIMIT_CYC + 4
      && gap_reg < SLOW_LIMIT_CYC - 4 |-> watchdog_fault_n [*6];
  endproperty
  a_wd_ok: assert property (p_wd_ok) else $error("false pulse");
  cover property ($rose(overvoltage_flag_n));
  cover property ($fell(watchdog_fault_n));
  cover property ($rose(supply_reset_n));
endmodule // supervisor_monitor
bind window_watchdog_supervisor supervisor_monitor #(.FAST_LIMIT_CYC(FAST_LIMIT_CYC),
  .SLOW_LIMIT_CYC(SLOW_LIMIT_CYC), .RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC),
  .FAST_PULSE_CYC(FAST_PULSE_CYC), .SLOW_PULSE_CYC(SLOW_PULSE_CYC)) mon_u (
  .clock(clock), .rstn(rstn), .in_window(in_window), .over_voltage(over_voltage),
  .fault_clear_n(fault_clear_n), .watchdog_strobe(watchdog_strobe),
  .supply_reset_n(supply_reset_n), .overvoltage_flag_n(overvoltage_flag_n),
  .watchdog_fault_n(watchdog_fault_n));

// File: sim/window_watchdog_supervisor_bench.sv
/* Self-checking bench for the supervisor core.
   Assumes mcu_model on the strobe and the checker bound to the core. */
`include "supervisor_defs.vh"
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  n_fail++; $display("Error %s expected %0d seen %0d", nm, exp, got); end end
module window_watchdog_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam RT = 50;
  localparam FP = 30;
  localparam SP = 60;
  logic clock, rstn, in_window, over_voltage, fault_clear_n;
  wire  watchdog_strobe, supply_reset_n, overvoltage_flag_n, watchdog_fault_n;
  logic [15:0] period;
  logic [31:0] seed = 32'hA961;
  int n_fail = 0;
  int comparisons = 0;
  window_watchdog_supervisor #(.FAST_LIMIT_CYC(20), .SLOW_LIMIT_CYC(200),
    .RESET_TIMEOUT_CYC(RT), .FAST_PULSE_CYC(FP), .SLOW_PULSE_CYC(SP)) dut_u (
    .clock(clock), .rstn(rstn), .in_window(in_window), .over_voltage(over_voltage),
    .fault_clear_n(fault_clear_n), .watchdog_strobe(watchdog_strobe),
    .supply_reset_n(supply_reset_n), .overvoltage_flag_n(overvoltage_flag_n),
    .watchdog_fault_n(watchdog_fault_n));
  mcu_model mcu_u (.clock(clock), .period(period), .watchdog_strobe(watchdog_strobe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Waits for a fault pulse and measures its length
  task automatic pulse(input int w);
    int k;
    k = 0;
    while (watchdog_fault_n && k < 400) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    while (!watchdog_fault_n && k < 400) begin
      @(negedge clock);
      k++;
    end
    `CHK("pulse", k, w)
  endtask
  task give_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict;
  end
  initial begin
    {in_window, over_voltage, period} = '0;
    fault_clear_n = 1;
    rstn = 0;
    wait_n(3);
    rstn = 1;
    `CHK("rst", supply_reset_n, 1'b0)
    `CHK("ovf", overvoltage_flag_n, 1'b1)
    in_window = 1;
    wait_n(RT - 2);
    `CHK("rst", supply_reset_n, 1'b0)
    wait_n(12);
    `CHK("rst", supply_reset_n, 1'b1)
    in_window = 0;
    wait_n(6);
    `CHK("rst", supply_reset_n, 1'b0)
    {in_window, over_voltage} = 2'b11;
    wait_n(150);
    over_voltage = 0;
    wait_n(RT + 10);
    `CHK("ovf", overvoltage_flag_n, 1'b1)
    over_voltage = 1;
    wait_n(`OV_DELAY_CYC + 8);
    `CHK("ovf", overvoltage_flag_n, 1'b0)
    fault_clear_n = 0;
    wait_n(`CLEAR_WIDTH_CYC + 20);
    `CHK("rst", supply_reset_n, 1'b1)
    over_voltage = 0;
    wait_n(20);
    `CHK("ovf", overvoltage_flag_n, 1'b0)
    fault_clear_n = 1;
    wait_n(RT + 10);
    `CHK("ovf", overvoltage_flag_n, 1'b0)
    fault_clear_n = 0;
    wait_n(100);
    fault_clear_n = 1;
    wait_n(5);
    `CHK("ovf", overvoltage_flag_n, 1'b0)
    fault_clear_n = 0;
    wait_n(`CLEAR_WIDTH_CYC + 20);
    `CHK("rst", supply_reset_n, 1'b0)
    fault_clear_n = 1;
    wait_n(RT + 10);
    `CHK("ovf", overvoltage_flag_n, 1'b1)
    `CHK("rst", supply_reset_n, 1'b1)
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      period = (i == 4) ? 16'h15 : (i == 7) ? 16'hC8 : 16'(30 + seed % 150);
      @(negedge watchdog_strobe);
      wait_n(4);
      `CHK("wdf", watchdog_fault_n, 1'b1)
    end
    period = 10;
    pulse(FP);
    period = 0;
    wait_n(60);
    pulse(SP);
    give_verdict;
  end
endmodule // window_watchdog_supervisor_bench
